// >>> codec_out1_map.svh
// Register offsets, field positions and reset values of the output channel 1 bank
`ifndef CODEC_OUT1_MAP_SVH
`define CODEC_OUT1_MAP_SVH

// Register indices; byte address is four times the index
`define NEG_CFG_IDX 10'h066
`define VOL_A_IDX 10'h067
`define FINE_A_IDX 10'h068
`define VOL_B_IDX 10'h069
`define FINE_B_IDX 10'h06a

// Reset values
`define NEG_CFG_RST 8'h20
`define VOL_RST 8'hc9
`define FINE_RST 8'h80
`define NEG_CFG_FIELDS_RST 7'h10
`define FINE_FIELD_RST 4'h8

// Field positions
`define DRV_POS 6
`define LVL_POS 3
`define FS_POS 1
`define CM_POS 0
`define FINE_POS 4

// Gain encoding
`define VOL_MUTE 8'h00
`define VOL_UNITY 8'hc9
`define FINE_UNITY 4'h8
`define VOL_STEP_TENTHS 13'sh005
`define LOG2_Q12_PER_TENTH 21'sh00044
`define LOG_FRAC_BITS 9'sh00c

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> codec_out1_pkg.sv
// Types shared by the output channel 1 configuration bank
package codec_out1_pkg;

   typedef enum logic [1:0] {
      DRV_LINE_OUT = 2'h0,
      DRV_HEADPHONE = 2'h1,
      DRV_FOUR_OHM = 2'h2,
      DRV_RECEIVER = 2'h3
   } neg_driver_t;

   typedef enum logic [2:0] {
      LVL_UNUSED0 = 3'h0,
      LVL_UNUSED1 = 3'h1,
      LVL_UNUSED2 = 3'h2,
      LVL_UNUSED3 = 3'h3,
      LVL_M8DB = 3'h4,
      LVL_M14DB = 3'h5,
      LVL_M20DB = 3'h6,
      LVL_M26DB = 3'h7
   } neg_level_t;

   typedef struct packed {
      neg_driver_t neg_out_driver_type;
      neg_level_t neg_out_level_select;
      logic ch1_full_scale_select;
      logic ch1_common_mode_tolerance;
   } neg_out_cfg_t;

   typedef struct packed {
      logic valid;
      logic signed [23:0] data;
   } audio_sample_t;

endpackage

// >>> sample_gain_stage.sv
// Applies combined volume and fine trim to one stream of audio samples
`timescale 1ns/1ps
`default_nettype none
`include "codec_out1_map.svh"

module sample_gain_stage
   import codec_out1_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire audio_sample_t sample_in,
   input wire logic [7:0] volume_code,
   input wire logic [3:0] fine_trim,
   output var audio_sample_t sample_out
);

   logic signed [12:0] vol_tenths;
   logic signed [12:0] total_tenths;
   logic signed [20:0] log_q12;
   logic signed [8:0] octave;
   logic [4:0] shamt;
   logic signed [37:0] product;
   logic signed [37:0] scaled;
   logic signed [23:0] clipped;

   // ------------------------------------------------------------
   // Gain in tenths of a dB, then log2 to shift and mantissa
   // ------------------------------------------------------------
   always_comb
   begin
      vol_tenths = 13'((signed'({5'h00, volume_code}) - signed'({5'h00, `VOL_UNITY}))
                   * `VOL_STEP_TENTHS); // see [RQ2] see [RQ3] see [RQ4]
      total_tenths = vol_tenths + signed'({9'h000, fine_trim})
                     - signed'({9'h000, `FINE_UNITY}); // see [RQ6] see [RQ7] see [RQ16]
      log_q12 = 21'(total_tenths) * `LOG2_Q12_PER_TENTH;
      octave = log_q12[20:12];
      shamt = 5'(`LOG_FRAC_BITS - octave);
      // Linear mantissa approximates 2^frac
      product = 38'(sample_in.data) * signed'({25'h0000000, 1'b1, log_q12[11:0]});
      scaled = product >>> shamt;
      if (scaled[37:23] != {15{scaled[37]}})
      begin
         clipped = scaled[37] ? 24'sh800000 : 24'sh7fffff;
      end
      else
      begin
         clipped = scaled[23:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sample_out <= '0;
      end
      else
      begin
         sample_out.valid <= sample_in.valid;
         // Mute wins over any trim
         sample_out.data <= (volume_code == `VOL_MUTE) ? 24'sh000000 : clipped; // see [RQ1]
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking

   default disable iff (rst);

   property p_mute;
      sample_in.valid && volume_code == `VOL_MUTE
         |=> sample_out.valid && sample_out.data == 24'sh000000;
   endproperty
   a_mute: assert property (p_mute) else $error("muted channel passed audio"); // see [RQ1]

   property p_unity;
      sample_in.valid && volume_code == `VOL_UNITY && fine_trim == `FINE_UNITY
         |=> sample_out.data == $past(sample_in.data);
   endproperty
   a_unity: assert property (p_unity) else $error("unity gain altered audio"); // see [RQ3]

   property p_floor;
      sample_in.valid && volume_code == 8'h01 && fine_trim == `FINE_UNITY
         && sample_in.data == 24'sh7fffff
         |=> sample_out.data > 24'sh00003c && sample_out.data < 24'sh00006e;
   endproperty
   a_floor: assert property (p_floor) else $error("code one not near -100 dB"); // see [RQ2]

   property p_top;
      sample_in.valid && volume_code == 8'hff && fine_trim == `FINE_UNITY
         && sample_in.data == 24'sh001000
         |=> sample_out.data > 24'sh014000 && sample_out.data < 24'sh018000;
   endproperty
   a_top: assert property (p_top) else $error("code 255 not near +27 dB"); // see [RQ4]

endmodule // sample_gain_stage
`default_nettype wire

// >>> dac_ch1_gain_output_config.sv
// Output channel 1 configuration bank with AXI4-Lite access and per-sample gain
// Contract
// [RQ1] Volume code zero fully mutes that sub-channel regardless of fine trim.
// [RQ2] Volume code one is -100 dB; each higher code adds 0.5 dB.
// [RQ3] Code 201 is unity; volume registers reset to 0xc9.
// [RQ4] Code 255 gives +27 dB, code 254 gives +26.5 dB.
// [RQ5] Sub-channel B volume is separate: A at 0x67, B at 0x69.
// [RQ6] Fine trim sits in bits 7-4; code 8 (reset) is 0 dB.
// [RQ7] Fine trim steps 0.1 dB from -0.8 dB up to +0.7 dB.
// [RQ8] Fine trim low nibble reads zero; software writes zero there.
// [RQ9] Bit 2 of the negative-output register reads zero.
// [RQ10] Driver field bits 7-6 select line, headphone, four-ohm, receiver; reset 0.
// [RQ11] Level field codes 4-7 give -8 to -26 dB; reset 4; 0-3 unused.
// [RQ12] Full-scale bit: clear 10 Vrms, set 5 Vrms differential.
// [RQ13] Coupling bit: clear limited common-mode tolerance, set rail to rail.
// [RQ14] Negative-output register at 0x66 resets to 0x20.
// [RQ15] Sub-channel B fine trim at 0x6a, same encoding, resets to 0x80.
// [RQ16] Volume and fine trim combine into one gain per sample; mute overrides.
`timescale 1ns/1ps
`default_nettype none
`include "codec_out1_map.svh"

module dac_ch1_gain_output_config
   import codec_out1_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire audio_sample_t sub_a_in,
   input wire audio_sample_t sub_b_in,
   output var audio_sample_t sub_a_out,
   output var audio_sample_t sub_b_out,
   output var neg_out_cfg_t neg_out_cfg
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0] vol_a_r;
   logic [7:0] vol_b_r;
   logic [3:0] fine_a_r;
   logic [3:0] fine_b_r;

   // ------------------------------------------------------------
   // Write channel state
   // ------------------------------------------------------------
   logic aw_held_r;
   logic w_held_r;
   logic aw_held_nxt;
   logic w_held_nxt;
   logic [9:0] wr_idx_r;
   logic [7:0] wr_byte_r;
   logic wr_lane_r;
   logic wr_fire;
   logic wr_hit;
   logic wr_en;
   logic bvalid_nxt;

   // ------------------------------------------------------------
   // Read channel state
   // ------------------------------------------------------------
   logic ar_fire;
   logic rvalid_nxt;
   logic [9:0] rd_idx;
   logic [7:0] rd_byte;
   logic rd_hit;

   // ------------------------------------------------------------
   // Write address and data capture, either order
   // ------------------------------------------------------------
   assign wr_fire = aw_held_r && w_held_r && !bvalid;

   // Fire clears a held half; a handshake sets it
   assign aw_held_nxt = !wr_fire && (aw_held_r || (awvalid && awready));
   assign w_held_nxt = !wr_fire && (w_held_r || (wvalid && wready));

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         aw_held_r <= 1'b0;
         awready <= 1'b0;
         wr_idx_r <= 10'h000;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         awready <= !aw_held_nxt;
         if (awvalid && awready)
         begin
            wr_idx_r <= awaddr[11:2];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         w_held_r <= 1'b0;
         wready <= 1'b0;
         wr_byte_r <= 8'h00;
         wr_lane_r <= 1'b0;
      end
      else
      begin
         w_held_r <= w_held_nxt;
         wready <= !w_held_nxt;
         if (wvalid && wready)
         begin
            wr_byte_r <= wdata[7:0];
            wr_lane_r <= wstrb[0];
         end
      end
   end

   // ------------------------------------------------------------
   // Write decode and response
   // ------------------------------------------------------------
   always_comb
   begin
      case (wr_idx_r)
         `NEG_CFG_IDX, `VOL_A_IDX, `FINE_A_IDX, `VOL_B_IDX, `FINE_B_IDX:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   assign wr_en = wr_fire && wr_hit && wr_lane_r;
   assign bvalid_nxt = wr_fire || (bvalid && !bready);

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end
      else
      begin
         bvalid <= bvalid_nxt;
         if (wr_fire)
         begin
            bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------
   // Negative-output configuration register
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         neg_out_cfg <= neg_out_cfg_t'(`NEG_CFG_FIELDS_RST); // see [RQ14]
      end
      else if (wr_en && wr_idx_r == `NEG_CFG_IDX)
      begin
         neg_out_cfg.neg_out_driver_type <=
            neg_driver_t'(wr_byte_r[`DRV_POS +: 2]); // see [RQ10]
         neg_out_cfg.neg_out_level_select <=
            neg_level_t'(wr_byte_r[`LVL_POS +: 3]); // see [RQ11]
         neg_out_cfg.ch1_full_scale_select <= wr_byte_r[`FS_POS]; // see [RQ12]
         neg_out_cfg.ch1_common_mode_tolerance <= wr_byte_r[`CM_POS]; // see [RQ13]
      end
   end

   // ------------------------------------------------------------
   // Volume registers, one per sub-channel
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         vol_a_r <= `VOL_RST; // see [RQ3]
         vol_b_r <= `VOL_RST; // see [RQ3]
      end
      else if (wr_en)
      begin
         if (wr_idx_r == `VOL_A_IDX)
         begin
            vol_a_r <= wr_byte_r; // see [RQ5]
         end
         if (wr_idx_r == `VOL_B_IDX)
         begin
            vol_b_r <= wr_byte_r; // see [RQ5]
         end
      end
   end

   // ------------------------------------------------------------
   // Fine trim registers, upper nibble only
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         fine_a_r <= `FINE_FIELD_RST; // see [RQ6]
         fine_b_r <= `FINE_FIELD_RST; // see [RQ15]
      end
      else if (wr_en)
      begin
         if (wr_idx_r == `FINE_A_IDX)
         begin
            fine_a_r <= wr_byte_r[`FINE_POS +: 4]; // see [RQ6]
         end
         if (wr_idx_r == `FINE_B_IDX)
         begin
            fine_b_r <= wr_byte_r[`FINE_POS +: 4]; // see [RQ15]
         end
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   assign ar_fire = arvalid && arready;
   assign rd_idx = araddr[11:2];
   assign rvalid_nxt = ar_fire || (rvalid && !rready);

   always_comb
   begin
      rd_hit = 1'b1;
      case (rd_idx)
         `NEG_CFG_IDX:
            rd_byte = {neg_out_cfg[6:2], 1'b0, neg_out_cfg[1:0]}; // see [RQ9]
         `VOL_A_IDX:
            rd_byte = vol_a_r;
         `FINE_A_IDX:
            rd_byte = {fine_a_r, 4'h0}; // see [RQ8]
         `VOL_B_IDX:
            rd_byte = vol_b_r;
         `FINE_B_IDX:
            rd_byte = {fine_b_r, 4'h0}; // see [RQ8]
         default:
         begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         arready <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end
      else
      begin
         rvalid <= rvalid_nxt;
         arready <= !rvalid_nxt;
         if (ar_fire)
         begin
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------
   // Gain stages
   // ------------------------------------------------------------
   sample_gain_stage u_gain_a (
      .clock(clock),
      .rst(rst),
      .sample_in(sub_a_in),
      .volume_code(vol_a_r),
      .fine_trim(fine_a_r),
      .sample_out(sub_a_out)
   ); // see [RQ16]

   sample_gain_stage u_gain_b (
      .clock(clock),
      .rst(rst),
      .sample_in(sub_b_in),
      .volume_code(vol_b_r),
      .fine_trim(fine_b_r),
      .sample_out(sub_b_out)
   ); // see [RQ16]

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking

   default disable iff (rst);

   sequence s_both_held;
      aw_held_r && w_held_r && !bvalid;
   endsequence

   sequence s_resp_up;
      bvalid ##1 (bvalid || $past(bready));
   endsequence

   property p_reset_vals;
      $past(rst) |-> vol_a_r == `VOL_RST && vol_b_r == `VOL_RST
         && fine_a_r == `FINE_FIELD_RST && fine_b_r == `FINE_FIELD_RST
         && neg_out_cfg == neg_out_cfg_t'(`NEG_CFG_FIELDS_RST);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // see [RQ14]

   property p_vol_b_alone;
      wr_en && wr_idx_r == `VOL_B_IDX |=> vol_b_r == $past(wr_byte_r) && $stable(vol_a_r);
   endproperty
   a_vol_b_alone: assert property (p_vol_b_alone) else $error("B volume write wrong"); // see [RQ5]

   property p_fine_rsvd;
      ar_fire && (rd_idx == `FINE_A_IDX || rd_idx == `FINE_B_IDX)
         |=> rvalid && rdata[3:0] == 4'h0 && rdata[7:4] == $past(rd_byte[7:4]);
   endproperty
   a_fine_rsvd: assert property (p_fine_rsvd) else $error("fine low nibble not zero"); // see [RQ8]

   property p_cfg_rsvd;
      ar_fire && rd_idx == `NEG_CFG_IDX |=> rvalid && rdata[2] == 1'b0 && rresp == `RESP_OKAY;
   endproperty
   a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config bit 2 not zero"); // see [RQ9]

   property p_cfg_write;
      wr_en && wr_idx_r == `NEG_CFG_IDX
         |=> neg_out_cfg.neg_out_level_select == $past(wr_byte_r[5:3])
         && neg_out_cfg.neg_out_driver_type == $past(wr_byte_r[7:6]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config fields not taken"); // see [RQ11]

   property p_write_resp;
      s_both_held |=> s_resp_up;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("write response missing");

endmodule // dac_ch1_gain_output_config
`default_nettype wire

// >>> test_dac_ch1_gain_output_config.sv
// Self-checking bench for the output channel 1 configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "codec_out1_map.svh"

module test_dac_ch1_gain_output_config
   import codec_out1_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   audio_sample_t sub_a_in = '0;
   audio_sample_t sub_b_in = '0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   audio_sample_t sub_a_out, sub_b_out;
   neg_out_cfg_t neg_out_cfg;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [7:0] v;
   logic signed [23:0] oa, ob;

   always #10 clock = ~clock;

   dac_ch1_gain_output_config u_dac_ch1_gain_output_config (
      .clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sub_a_in(sub_a_in), .sub_b_in(sub_b_in), .sub_a_out(sub_a_out),
      .sub_b_out(sub_b_out), .neg_out_cfg(neg_out_cfg)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic check_range(input string name, input int lo, input int hi,
                              input logic signed [23:0] seen);
      n_checks++;
      if ($isunknown(seen) || $signed(seen) < lo || $signed(seen) > hi)
      begin
         error_cnt++;
         $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, seen);
      end
   endtask

   task automatic bus_write(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] strb,
                            input logic [1:0] exp_resp);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clock);
      awaddr <= {idx, 2'b00};
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= strb;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clock);
         if (!aw_ok && awready)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (!bvalid);
      bready <= 1'b0;
      check_val("bresp", {30'h0, exp_resp}, {30'h0, bresp});
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bus_write(idx, d, 4'h1, `RESP_OKAY);
   endtask

   task automatic bus_read(input logic [9:0] idx, input logic [7:0] exp,
                           input logic [1:0] exp_resp);
      @(posedge clock);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      rready <= 1'b0;
      check_val("rdata", {24'h000000, exp}, rdata);
      check_val("rresp", {30'h0, exp_resp}, {30'h0, rresp});
   endtask

   // One sample on each sub-channel, result captured in the answer cycle
   task automatic send(input logic signed [23:0] da, input logic signed [23:0] db);
      @(posedge clock);
      sub_a_in <= {1'b1, da};
      sub_b_in <= {1'b1, db};
      @(posedge clock);
      sub_a_in <= '0;
      sub_b_in <= '0;
      #1;
      check_val("a valid", 32'h1, {31'h0, sub_a_out.valid});
      check_val("b valid", 32'h1, {31'h0, sub_b_out.valid});
      oa = sub_a_out.data;
      ob = sub_b_out.data;
   endtask

   task automatic end_test(input string name);
      $display("test %s done: checks %0d mismatches %0d", name, n_checks, error_cnt);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         error_cnt++;
         $display("BAD watchdog expected done seen hang");
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      check_val("cfg out", 32'h10, {25'h0, neg_out_cfg});
      bus_read(`NEG_CFG_IDX, 8'h20, `RESP_OKAY);
      bus_read(`VOL_A_IDX, 8'hc9, `RESP_OKAY);
      bus_read(`FINE_A_IDX, 8'h80, `RESP_OKAY);
      bus_read(`VOL_B_IDX, 8'hc9, `RESP_OKAY);
      bus_read(`FINE_B_IDX, 8'h80, `RESP_OKAY);
      end_test("reset");
      // Every driver type and level codes 4-7, reserved bit written high
      for (int i = 0; i < 4; i++)
      begin
         v = {i[1:0], 3'h4 + i[2:0], 1'b1, i[0], i[1]};
         wr(`NEG_CFG_IDX, v);
         bus_read(`NEG_CFG_IDX, v & 8'hfb, `RESP_OKAY);
         check_val("cfg out", {25'h0, v[7:3], v[1:0]}, {25'h0, neg_out_cfg});
      end
      // Low nibble of fine trim written as zero only
      wr(`FINE_A_IDX, 8'hf0);
      bus_read(`FINE_A_IDX, 8'hf0, `RESP_OKAY);
      wr(`FINE_B_IDX, 8'h30);
      bus_read(`FINE_B_IDX, 8'h30, `RESP_OKAY);
      bus_read(`FINE_A_IDX, 8'hf0, `RESP_OKAY);
      bus_write(`VOL_A_IDX, 8'h55, 4'h0, `RESP_OKAY);
      bus_read(`VOL_A_IDX, 8'hc9, `RESP_OKAY);
      bus_write(10'h06b, 8'h12, 4'h1, `RESP_SLVERR);
      bus_read(10'h065, 8'h00, `RESP_SLVERR);
      bus_read(`NEG_CFG_IDX, v & 8'hfb, `RESP_OKAY);
      end_test("registers");
      wr(`FINE_A_IDX, 8'h80);
      wr(`FINE_B_IDX, 8'h80);
      send(24'sh123456, -24'sh010000);
      check_range("a unity", 'h123456, 'h123456, oa);
      check_range("b unity", -65536, -65536, ob);
      wr(`FINE_B_IDX, 8'hf0);
      wr(`VOL_B_IDX, 8'h00);
      send(24'sh123456, -24'sh7fffff);
      check_range("a beside mute", 'h123456, 'h123456, oa);
      check_range("b mute", 0, 0, ob);
      wr(`VOL_A_IDX, 8'h01);
      send(24'sh7fffff, 24'sh000100);
      check_range("a vol 1", 74, 95, oa);
      wr(`VOL_A_IDX, 8'hff);
      send(24'sh001000, 24'sh000100);
      check_range("a vol 255", 81000, 103000, oa);
      wr(`VOL_A_IDX, 8'hfe);
      send(24'sh001000, 24'sh000100);
      check_range("a vol 254", 77150, 97130, oa);
      wr(`VOL_A_IDX, 8'hc9);
      wr(`FINE_A_IDX, 8'h00);
      send(24'sh100000, 24'sh000100);
      check_range("a fine 0", 850000, 1075000, oa);
      wr(`FINE_A_IDX, 8'hf0);
      send(24'sh100000, 24'sh000100);
      check_range("a fine 15", 1013000, 1280000, oa);
      wr(`FINE_A_IDX, 8'h90);
      send(24'sh100000, 24'sh000100);
      check_range("a fine 9", 945000, 1191000, oa);
      wr(`VOL_A_IDX, 8'h00);
      send(-24'sh400000, 24'sh000100);
      check_range("a mute", 0, 0, oa);
      end_test("gain");
      conclude();
   end

endmodule // test_dac_ch1_gain_output_config
`default_nettype wire
